// [rtl/lcr_pkg.sv]
/*
 * Constants of the configurable logic cell register block: register offsets,
 * field positions, reset values and the function modes.
 * Assumes an 8-bit register port with a 4-bit word address.
 */
package lcr_pkg;

	// ==========================================================
	// Register offsets (word index on the register port)
	localparam logic [3:0] LCR_OFS_CTRL = 4'h0;
	localparam logic [3:0] LCR_OFS_POL = 4'h1;
	localparam logic [3:0] LCR_OFS_SEL1 = 4'h2;
	localparam logic [3:0] LCR_OFS_SEL2 = 4'h3;
	localparam logic [3:0] LCR_OFS_SEL3 = 4'h4;
	localparam logic [3:0] LCR_OFS_SEL4 = 4'h5;
	localparam logic [3:0] LCR_OFS_GATE1 = 4'h6;
	localparam logic [3:0] LCR_OFS_GATE2 = 4'h7;
	localparam logic [3:0] LCR_OFS_GATE3 = 4'h8;
	localparam logic [3:0] LCR_OFS_GATE4 = 4'h9;
	localparam logic [3:0] LCR_OFS_FLAG = 4'hA;

	// ==========================================================
	// Field positions
	localparam int LCR_BIT_EN = 7;
	localparam int LCR_BIT_OUT = 5;
	localparam int LCR_BIT_RISE = 4;
	localparam int LCR_BIT_FALL = 3;
	localparam int LCR_BIT_OINV = 7;
	localparam int LCR_BIT_FLAG = 0;
	localparam int LCR_SRC_W = 5;
	localparam int LCR_MODE_W = 3;

	// ==========================================================
	// Reset values
	localparam logic [7:0] LCR_RST_CTRL = 8'h00;
	localparam logic LCR_RST_OINV = 1'b0;
	localparam logic LCR_RST_FLAG = 1'b0;

	// ==========================================================
	// Function modes, in code order 000 to 111
	typedef enum logic [2:0] {
		LCR_AND_OR,
		LCR_OR_XOR,
		LCR_AND4,
		LCR_SR_LATCH,
		LCR_DFF_SR,
		LCR_DFF2_R,
		LCR_JK_R,
		LCR_DLATCH_SR
	} lcr_mode_e;

endpackage : lcr_pkg

// [rtl/lcr_sync3.sv]
/*
 * Three-stage input synchroniser, one lane per bit.
 * Assumes asynchronous inputs; a change is taken once stages two and three agree.
 */
`timescale 1ns/100ps
module lcr_sync3 #(
	parameter int W = 32
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);

	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] out_q;

	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_lane
			always_ff @(posedge clk) begin
				if (!rst_n) begin
					s1_q[i] <= 1'b0;
					s2_q[i] <= 1'b0;
					s3_q[i] <= 1'b0;
					out_q[i] <= 1'b0;
				end else if (ce) begin
					s1_q[i] <= din[i];
					s2_q[i] <= s1_q[i];
					s3_q[i] <= s2_q[i];
					if (s2_q[i] == s3_q[i]) begin
						out_q[i] <= s3_q[i];
					end
				end
			end
		end
	endgenerate

	assign dout = out_q;

endmodule : lcr_sync3

// [rtl/lcr_cell.sv]
/*
 * One configurable logic cell with its control and configuration registers:
 * input selection, four data gates, eight-mode function stage, output polarity,
 * output readback and edge-driven event flag.
 * Assumes a plain register port (read data one cycle after the read strobe)
 * and asynchronous source inputs, which are synchronised here.
 */
// Behaviour
// - Enable bit 7 of control lets the cell run; clear forces output zero.
// - Control bit 5 reads back the cell output after output polarity.
// - Rising enable, control bit 4, lets output rising edges set the flag.
// - Falling enable, control bit 3, lets output falling edges set the flag.
// - Mode 111: transparent latch with one data input, set and reset.
// - Mode 110: J-K flip-flop with reset.
// - Mode 101: D flip-flop with two data inputs and reset.
// - Mode 100: D flip-flop with one data input, set and reset.
// - Mode 011: set-reset latch from the gate outputs.
// - Modes 010, 001, 000: four-input AND, OR-XOR, AND-OR.
// - Polarity bit 7 inverts the function result into the cell output.
// - Polarity bits 0-3 invert gates 1-4; bits 6-4 read zero.
// - Four select registers pick data 1-4 sources in bits 4-0; upper zero.
// - Gate select bit pairs admit true and negated data 4 down to 1.
// - Each gate ANDs all admitted true or negated data signals.
// - A gate with nothing admitted yields a constant set by its polarity.
// - Reset clears control, output polarity bit 7 and the flag; selection, gates and gate polarity stay.
// - Software clears the flag; a coincident enabled edge keeps it set.
`timescale 1ns/100ps
module lcr_cell
	import lcr_pkg::*;
#(
	parameter int NUM_SRC = 32
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	output logic [7:0] reg_rdata,
	input wire logic [NUM_SRC-1:0] cell_in,
	output logic cell_out,
	output logic cell_irq_flag
);

	// ==========================================================
	// Register state
	logic cell_enable_q;
	logic rise_irq_enable_q;
	logic fall_irq_enable_q;
	logic [LCR_MODE_W-1:0] function_mode_q;
	logic output_invert_q;
	logic [3:0] gate_invert_q;
	logic [LCR_SRC_W-1:0] data_source_q [4];
	logic [7:0] gate_sel_q [4];
	logic flag_q;
	logic flag_d;
	logic [7:0] rdata_q;
	logic [7:0] rdata_d;

	// ==========================================================
	// Address decode
	wire wr_ctrl = reg_we && (reg_addr == LCR_OFS_CTRL);
	wire wr_pol = reg_we && (reg_addr == LCR_OFS_POL);
	wire wr_flag = reg_we && (reg_addr == LCR_OFS_FLAG);
	wire [3:0] wr_sel;
	wire [3:0] wr_gate;
	assign wr_sel[0] = reg_we && (reg_addr == LCR_OFS_SEL1);
	assign wr_sel[1] = reg_we && (reg_addr == LCR_OFS_SEL2);
	assign wr_sel[2] = reg_we && (reg_addr == LCR_OFS_SEL3);
	assign wr_sel[3] = reg_we && (reg_addr == LCR_OFS_SEL4);
	assign wr_gate[0] = reg_we && (reg_addr == LCR_OFS_GATE1);
	assign wr_gate[1] = reg_we && (reg_addr == LCR_OFS_GATE2);
	assign wr_gate[2] = reg_we && (reg_addr == LCR_OFS_GATE3);
	assign wr_gate[3] = reg_we && (reg_addr == LCR_OFS_GATE4);

	// ==========================================================
	// Control register and output polarity bit, both cleared by reset
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cell_enable_q <= LCR_RST_CTRL[LCR_BIT_EN];
			rise_irq_enable_q <= LCR_RST_CTRL[LCR_BIT_RISE];
			fall_irq_enable_q <= LCR_RST_CTRL[LCR_BIT_FALL];
			function_mode_q <= LCR_RST_CTRL[LCR_MODE_W-1:0];
			output_invert_q <= LCR_RST_OINV;
		end else if (ce) begin
			if (wr_ctrl) begin
				cell_enable_q <= reg_wdata[LCR_BIT_EN];
				rise_irq_enable_q <= reg_wdata[LCR_BIT_RISE];
				fall_irq_enable_q <= reg_wdata[LCR_BIT_FALL];
				function_mode_q <= reg_wdata[LCR_MODE_W-1:0];
			end
			if (wr_pol) begin
				output_invert_q <= reg_wdata[LCR_BIT_OINV];
			end
		end
	end

	// Configuration that survives reset, undefined until first written.
	// No reset branch on purpose: a reset must keep the user's routing.
	always_ff @(posedge clk) begin
		if (ce && wr_pol) begin
			gate_invert_q <= reg_wdata[3:0];
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_cfg
			always_ff @(posedge clk) begin
				if (ce && wr_sel[gi]) begin
					data_source_q[gi] <= reg_wdata[LCR_SRC_W-1:0];
				end
				if (ce && wr_gate[gi]) begin
					gate_sel_q[gi] <= reg_wdata;
				end
			end
		end
	endgenerate

	// ==========================================================
	// Input synchronisation and data selection
	logic [NUM_SRC-1:0] in_sync;
	logic [3:0] data_true;
	logic [3:0] gate_raw;
	logic [3:0] gate_out;

	lcr_sync3 #(
		.W(NUM_SRC)
	) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.din(cell_in),
		.dout(in_sync)
	);

	// ==========================================================
	// Data gates: bit 2k+1 admits data k+1 true, bit 2k admits it negated
	generate
		for (gi = 0; gi < 4; gi++) begin : g_gate
			logic [3:0] term;
			assign data_true[gi] = in_sync[data_source_q[gi]];
			for (genvar k = 0; k < 4; k++) begin : g_term
				assign term[k] = (~gate_sel_q[gi][2*k+1] | data_true[k])
					& (~gate_sel_q[gi][2*k] | ~data_true[k]);
			end
			// Empty gate gives zero before inversion
			assign gate_raw[gi] = (|gate_sel_q[gi]) & (&term);
			assign gate_out[gi] = gate_raw[gi] ^ gate_invert_q[gi];
		end
	endgenerate

	wire g1 = gate_out[0];
	wire g2 = gate_out[1];
	wire g3 = gate_out[2];
	wire g4 = gate_out[3];

	// ==========================================================
	// Function stage; flip-flop modes are stepped on sampled g1 rising edges.
	// A gate pulse shorter than a clock period plus the synchroniser window
	// is lost here, unlike in a self-clocked cell; users must keep inputs slow.
	logic g1_prev_q;
	logic state_q;
	logic state_d;
	logic func_out;
	wire g1_rise = g1 & ~g1_prev_q;
	lcr_mode_e mode;
	assign mode = lcr_mode_e'(function_mode_q);

	always_comb begin
		state_d = state_q;
		func_out = state_q;
		case (mode)
			LCR_AND_OR: begin
				func_out = (g1 & g2) | (g3 & g4);
			end
			LCR_OR_XOR: begin
				func_out = (g1 | g2) ^ (g3 | g4);
			end
			LCR_AND4: begin
				func_out = g1 & g2 & g3 & g4;
			end
			LCR_SR_LATCH: begin
				// Set from g1|g2, reset from g3|g4, reset dominant
				if (g3 | g4) begin
					state_d = 1'b0;
				end else if (g1 | g2) begin
					state_d = 1'b1;
				end
				func_out = state_d;
			end
			LCR_DFF_SR: begin
				// Clock g1, data g2, reset g3, set g4
				if (g3) begin
					state_d = 1'b0;
				end else if (g4) begin
					state_d = 1'b1;
				end else if (g1_rise) begin
					state_d = g2;
				end
				func_out = state_d;
			end
			LCR_DFF2_R: begin
				// Clock g1, data g2 and g4 ANDed, reset g3
				if (g3) begin
					state_d = 1'b0;
				end else if (g1_rise) begin
					state_d = g2 & g4;
				end
				func_out = state_d;
			end
			LCR_JK_R: begin
				// Clock g1, J g2, K g4, reset g3
				if (g3) begin
					state_d = 1'b0;
				end else if (g1_rise) begin
					case ({g2, g4})
						2'b10: state_d = 1'b1;
						2'b01: state_d = 1'b0;
						2'b11: state_d = ~state_q;
						default: state_d = state_q;
					endcase
				end
				func_out = state_d;
			end
			LCR_DLATCH_SR: begin
				// Enable g1 (transparent high), data g2, reset g3, set g4
				if (g3) begin
					state_d = 1'b0;
				end else if (g4) begin
					state_d = 1'b1;
				end else if (g1) begin
					state_d = g2;
				end
				func_out = state_d;
			end
			default: begin
				func_out = 1'b0;
			end
		endcase
	end

	// Disabled cell shows zero after the polarity stage
	wire cell_out_d = cell_enable_q & (func_out ^ output_invert_q);

	logic cell_out_q;

	// State is held clear while disabled so a re-enable starts from zero
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			g1_prev_q <= 1'b0;
			state_q <= 1'b0;
			cell_out_q <= 1'b0;
		end else if (ce) begin
			g1_prev_q <= g1;
			state_q <= cell_enable_q ? state_d : 1'b0;
			cell_out_q <= cell_out_d;
		end
	end

	// ==========================================================
	// Edge detection and event flag
	// The output is already on this clock; the three stages keep the edge
	// timing the same as for a cell whose output were asynchronous.
	logic out_s1_q;
	logic out_s2_q;
	logic out_s3_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			out_s1_q <= 1'b0;
			out_s2_q <= 1'b0;
			out_s3_q <= 1'b0;
		end else if (ce) begin
			out_s1_q <= cell_out_q;
			out_s2_q <= out_s1_q;
			out_s3_q <= out_s2_q;
		end
	end

	wire rise_evt = rise_irq_enable_q & out_s2_q & ~out_s3_q;
	wire fall_evt = fall_irq_enable_q & ~out_s2_q & out_s3_q;
	wire flag_clr = wr_flag & ~reg_wdata[LCR_BIT_FLAG];

	// Set wins over a clear in the same cycle
	assign flag_d = rise_evt | fall_evt | (flag_q & ~flag_clr);

	// ==========================================================
	// Read path: data stand for one cycle after the strobe
	// Control, polarity, flag and select have named read views; unimplemented bits read low
	wire [7:0] ctrl_view = {cell_enable_q, 1'b0, cell_out_q, rise_irq_enable_q,
		fall_irq_enable_q, function_mode_q};
	wire [7:0] pol_view = {output_invert_q, 3'h0, gate_invert_q};
	wire [7:0] flag_view = {7'h00, flag_q};
	wire [7:0] sel_view [4];

	generate
		for (gi = 0; gi < 4; gi++) begin : g_view
			assign sel_view[gi] = {3'h0, data_source_q[gi]};
		end
	endgenerate

	always_comb begin
		rdata_d = 8'h00;
		if (reg_re) begin
			case (reg_addr)
				LCR_OFS_CTRL: rdata_d = ctrl_view;
				LCR_OFS_POL: rdata_d = pol_view;
				LCR_OFS_SEL1: rdata_d = sel_view[0];
				LCR_OFS_SEL2: rdata_d = sel_view[1];
				LCR_OFS_SEL3: rdata_d = sel_view[2];
				LCR_OFS_SEL4: rdata_d = sel_view[3];
				LCR_OFS_GATE1: rdata_d = gate_sel_q[0];
				LCR_OFS_GATE2: rdata_d = gate_sel_q[1];
				LCR_OFS_GATE3: rdata_d = gate_sel_q[2];
				LCR_OFS_GATE4: rdata_d = gate_sel_q[3];
				LCR_OFS_FLAG: rdata_d = flag_view;
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			flag_q <= LCR_RST_FLAG;
			rdata_q <= 8'h00;
		end else if (ce) begin
			flag_q <= flag_d;
			rdata_q <= rdata_d;
		end
	end

	assign reg_rdata = rdata_q;
	assign cell_out = cell_out_q;
	assign cell_irq_flag = flag_q;

endmodule : lcr_cell

// [verif/lcr_cell_props.sv]
/*
 * Port assertions and covers for the logic cell register block.
 * Assumes the bench drives the register port; checks other than the reset check pause while ce is low.
 */
`timescale 1ns/100ps
module lcr_cell_chk
	import lcr_pkg::*;
#(
	parameter int NUM_SRC = 32
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_we,
	input wire logic reg_re,
	input wire logic [7:0] reg_rdata,
	input wire logic [NUM_SRC-1:0] cell_in,
	input wire logic cell_out,
	input wire logic cell_irq_flag
);
	// ==========================================
	// Decodes
	wire rd_ctrl = reg_re && reg_addr == LCR_OFS_CTRL;
	wire rd_sel = reg_re && reg_addr >= LCR_OFS_SEL1 && reg_addr <= LCR_OFS_SEL4;
	wire wr_off = reg_we && reg_addr == LCR_OFS_CTRL && !reg_wdata[LCR_BIT_EN];
	wire flag_clr = reg_we && reg_addr == LCR_OFS_FLAG && !reg_wdata[LCR_BIT_FLAG];
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n || !ce);
	// ==========================================
	// Assertions
	rdata_idle_a: assert property (!reg_re |=> reg_rdata == 8'h00)
		else $error("read data not zero outside a read");
	out_readback_a: assert property (rd_ctrl |=> reg_rdata[5] == $past(cell_out) && !reg_rdata[6])
		else $error("control readback wrong");
	pol_reserved_a: assert property (reg_re && reg_addr == LCR_OFS_POL |=> reg_rdata[6:4] == 3'h0)
		else $error("polarity reserved bits set");
	sel_reserved_a: assert property (rd_sel |=> reg_rdata[7:5] == 3'h0)
		else $error("select reserved bits set");
	unmapped_zero_a: assert property (reg_re && reg_addr > LCR_OFS_FLAG |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	off_output_a: assert property (wr_off |-> ##[1:3] !cell_out)
		else $error("output not zero after disable");
	flag_sticky_a: assert property (cell_irq_flag && !flag_clr |=> cell_irq_flag)
		else $error("flag dropped without clear");
	flag_cause_a: assert property ($rose(cell_irq_flag) |-> $past(cell_out, 3) != $past(cell_out, 4))
		else $error("flag set without output edge");
	reset_clear_a: assert property (disable iff (1'b0) !rst_n |=> !cell_out && !cell_irq_flag)
		else $error("reset did not clear outputs");
	cover property ($rose(cell_irq_flag));
	cover property ($fell(cell_out));
	cover property (rd_ctrl ##1 reg_rdata[5]);
endmodule : lcr_cell_chk

bind lcr_cell lcr_cell_chk #(.NUM_SRC(NUM_SRC)) u_lcr_cell_chk (.clk(clk), .rst_n(rst_n),
	.ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
	.reg_rdata(reg_rdata), .cell_in(cell_in), .cell_out(cell_out),
	.cell_irq_flag(cell_irq_flag));

// [verif/tb_lcr_cell.sv]
/*
 * Self-checking bench for the logic cell register block.
 * Assumes the lcr_pkg offsets and a 100 MHz clock; ce is held high except in the clock enable test.
 */
`timescale 1ns/100ps
module tb_lcr_cell
	import lcr_pkg::*;
;
	// ==========================================
	// Stimulus and checking
	localparam logic [47:0] SEQ_TBL [5] = '{48'h111004000512, 48'h021311100118,
		48'h0A1B1A120307, 48'h021318090A1B, 48'h13010002180C};
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic ce = 1'b1;
	logic we = 1'b0;
	logic re = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdat = 8'h00;
	logic [31:0] cin = 32'h0;
	logic [7:0] rdat;
	logic cout;
	logic flag;
	int error_cnt = 0;
	int compares = 0;
	initial forever #5 clk = ~clk;
	lcr_cell u_lcr_cell (.clk(clk), .rst_n(rst_n), .ce(ce), .reg_addr(addr),
		.reg_wdata(wdat), .reg_we(we), .reg_re(re), .reg_rdata(rdat), .cell_in(cin),
		.cell_out(cout), .cell_irq_flag(flag));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdat <= d;
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		re <= 1'b1;
		@(posedge clk);
		re <= 1'b0;
		#1 chk(rdat, exp);
	endtask : rd
	task automatic settle;
		repeat (8) @(posedge clk);
		#1;
	endtask : settle
	task automatic step(input logic [3:0] v, input logic e);
		@(posedge clk);
		cin[3:0] <= v;
		settle();
		chk({7'h0, cout}, {7'h0, e});
	endtask : step
	task automatic cfg(input logic [31:0] g, input logic [7:0] p);
		for (int i = 0; i < 4; i++) begin
			wr(LCR_OFS_SEL1 + i[3:0], i[7:0]);
			wr(LCR_OFS_GATE1 + i[3:0], g[8*i+:8]);
		end
		wr(LCR_OFS_POL, p);
	endtask : cfg
	task automatic t_regs;
		rd(LCR_OFS_CTRL, 8'h00);
		wr(4'hB, 8'hFF);
		rd(4'hB, 8'h00);
		for (int i = 0; i < 4; i++) begin
			wr(LCR_OFS_SEL1 + i[3:0], 8'hFF);
			rd(LCR_OFS_SEL1 + i[3:0], 8'h1F);
		end
		wr(LCR_OFS_POL, 8'hFF);
		rd(LCR_OFS_POL, 8'h8F);
		wr(LCR_OFS_GATE1, 8'hA5);
		rd(LCR_OFS_GATE1, 8'hA5);
		wr(LCR_OFS_CTRL, 8'h7F);
		rd(LCR_OFS_CTRL, 8'h1F);
		@(posedge clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd(LCR_OFS_CTRL, 8'h00);
		rd(LCR_OFS_POL, 8'h0F);
		rd(LCR_OFS_GATE1, 8'hA5);
		$display("register test done");
	endtask : t_regs
	task automatic t_comb;
		logic [3:0] g;
		logic e;
		cfg(32'h40200402, 8'h04);
		for (int p = 0; p < 2; p++) begin
			wr(LCR_OFS_POL, {p[0], 7'h04});
			for (int m = 0; m < 3; m++) begin
				wr(LCR_OFS_CTRL, 8'h80 | m[7:0]);
				for (int v = 0; v < 16; v++) begin
					g = v[3:0] ^ 4'hE;
					e = p[0] ^ ((m == 0) ? ((g[0] & g[1]) | (g[2] & g[3])) :
						(m == 1) ? ((g[0] | g[1]) ^ (g[2] | g[3])) : &g);
					step(v[3:0], e);
					rd(LCR_OFS_CTRL, {2'b10, e, 2'b00, m[2:0]});
				end
			end
		end
		$display("combinational test done");
	endtask : t_comb
	task automatic t_irq;
		cfg(32'h0, 8'h00);
		wr(LCR_OFS_CTRL, 8'h02);
		wr(LCR_OFS_POL, 8'h0F);
		step(4'h0, 1'b0);
		wr(LCR_OFS_POL, 8'h00);
		wr(LCR_OFS_FLAG, 8'h00);
		wr(LCR_OFS_CTRL, 8'h92);
		wr(LCR_OFS_POL, 8'h0F);
		settle();
		chk({7'h0, cout}, 8'h01);
		rd(LCR_OFS_FLAG, 8'h01);
		wr(LCR_OFS_FLAG, 8'h00);
		rd(LCR_OFS_FLAG, 8'h00);
		wr(LCR_OFS_POL, 8'h00);
		settle();
		chk({7'h0, flag}, 8'h00);
		wr(LCR_OFS_CTRL, 8'h8A);
		wr(LCR_OFS_POL, 8'h0F);
		settle();
		chk({7'h0, flag}, 8'h00);
		wr(LCR_OFS_POL, 8'h00);
		settle();
		chk({7'h0, flag}, 8'h01);
		$display("event flag test done");
	endtask : t_irq
	task automatic t_seq;
		cfg(32'h80200802, 8'h00);
		for (int m = 3; m < 8; m++) begin
			wr(LCR_OFS_CTRL, 8'h00);
			step(4'h0, 1'b0);
			wr(LCR_OFS_CTRL, 8'h80 | m[7:0]);
			for (int i = 5; i >= 0; i--) begin
				step(SEQ_TBL[m-3][8*i+:4], SEQ_TBL[m-3][8*i+4]);
			end
		end
		$display("sequential test done");
	endtask : t_seq
	task automatic t_ce;
		@(posedge clk);
		ce <= 1'b0;
		wr(LCR_OFS_CTRL, 8'h00);
		@(posedge clk);
		ce <= 1'b1;
		rd(LCR_OFS_CTRL, 8'h87);
		$display("clock enable test done");
	endtask : t_ce
	task automatic test_done;
		$display("compares=%0d errors=%0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : test_done
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_comb();
		t_irq();
		t_seq();
		t_ce();
		test_done();
	end
endmodule : tb_lcr_cell
